// >>> core/bmc_pkg.sv
// Package of offsets, field positions, codes and timing for the control/status registers.
package bmc_pkg;

    // Register offsets inside the slave window.
    localparam logic [7:0] BMC_MODE_CMD_OFS   = 8'h1C;
    localparam logic [7:0] BMC_IRQ_ID_OFS     = 8'h1E;
    localparam logic [7:0] BMC_CYC_CNT_OFS    = 8'h0E;

    // Field positions of the mode_command_status register.
    localparam int BMC_BUS_SEL_BIT    = 0;
    localparam int BMC_LATCHED_BIT    = 1;
    localparam int BMC_MONITOR_BIT    = 2;
    localparam int BMC_DIR_BIT        = 3;
    localparam int BMC_A64_BIT        = 4;
    localparam int BMC_D64_BIT        = 5;
    localparam int BMC_SYSCON_BIT     = 6;
    localparam int BMC_SLOT0_BIT      = 7;
    localparam int BMC_IRQ_PULSE_BIT  = 6;
    localparam int BMC_FREE_RUN_BIT   = 7;
    localparam int BMC_MODE_LSB       = 8;
    localparam int BMC_CNT_SEL_BIT    = 10;
    localparam int BMC_SOFT_RST_BIT   = 11;
    localparam int BMC_DELAY_LSB      = 12;

    // Field positions of the interrupt_id_level_status register; the counter select reads back at bit 12 of the cycle counter register.
    localparam int BMC_LEVEL_LSB      = 8;
    localparam int BMC_PENDING_BIT    = 11;
    localparam int BMC_SEL_READ_BIT   = 12;

    // Delay value after reset, and the code for no mode command.
    localparam logic [3:0] BMC_DELAY_RST  = 4'hF;
    localparam logic [1:0] BMC_MODE_CMD_NONE = 2'h0;

    // Mode command codes.
    localparam logic [1:0] BMC_CMD_LATCHED = 2'h1;
    localparam logic [1:0] BMC_CMD_DIRECT  = 2'h2;
    localparam logic [1:0] BMC_CMD_MONITOR = 2'h3;

    // Display modes, one-hot.
    typedef enum logic [2:0] {
        BMC_MODE_LATCHED = 3'h1,
        BMC_MODE_DIRECT  = 3'h2,
        BMC_MODE_MONITOR = 3'h4
    } bmc_mode_t;

    // Timing figures in picoseconds, nanoseconds and microseconds, and the clock period.
    localparam int BMC_CLK_PS        = 25000;
    localparam int BMC_ACK_WR_BASE_PS = 96750;
    localparam int BMC_ACK_RD_BASE_PS = 128000;
    localparam int BMC_ACK_STEP_PS   = 31250;
    localparam int BMC_RESET_PULSE_NS = 200;
    localparam int BMC_BTO_SHORT_US  = 15;
    localparam int BMC_BTO_LONG_US   = 255;

    // Derived counts: least times round up.
    localparam int BMC_RESET_PULSE_CYC =
        (BMC_RESET_PULSE_NS * 1000 + BMC_CLK_PS - 1) / BMC_CLK_PS;
    localparam int BMC_BTO_SHORT_CYC = (BMC_BTO_SHORT_US * 1000000) / BMC_CLK_PS;
    localparam int BMC_BTO_LONG_CYC  = (BMC_BTO_LONG_US * 1000000) / BMC_CLK_PS;
    localparam int BMC_BLT_MAX       = 255;

endpackage : bmc_pkg

// >>> core/bmc_sync.sv
// Two-flop synchroniser for a vector of asynchronous panel inputs.
`timescale 1ns/1ps
`default_nettype none
module bmc_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk, // System clock.
    input  wire logic             nrst,     // Synchronous reset, active low.
    input  wire logic [WIDTH-1:0] async_in, // Asynchronous inputs.
    output logic      [WIDTH-1:0] sync_out  // Synchronised inputs.
);
    logic [WIDTH-1:0] stage1_reg;

    // Elaboration check: an empty vector cannot be synchronised.
    if (WIDTH < 1) begin : g_bad_width
        $error("bmc_sync needs a positive width.");
    end

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule : bmc_sync
`default_nettype wire

// >>> core/bmc_regs.sv
// Control and status registers of the bus display module with panel inputs.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Low nibble read, high byte write, middle both
// - Bit 0 reads bus select switch
// - A64 and D64 together give 64-bit display
// - Bits 6,7 read controller and slot0
// - Bit 4 A64 only when switch A32
// - Bit 5 D64 only when switch D32
// - Software pulse on bit 6 raises interrupt
// - Bit 7 selects counter free running
// - Bits 9:8 command three mode actions
// - Bit 10 picks counter bus, readable bit 12
// - Bit 11 resets backplane if jumper fitted
// - Bits 15:12 set monitor acknowledge delay
// - Delay 96.75/128 ns plus 31.25 ns steps
// - Second register low byte: jumpered vector
// - Bits 10:8 show jumpered interrupt level
// - Bit 11 shows interrupt pending
// - Bits 15:12 undefined, read zero here
// - Test switch shows counters on address lights
// - Timeout switch picks 15 or 255 us
// - Stop switches and round-robin arbitration select
// - Panel switch clears or steps modes
// - External input gives interrupt or reset
// - Buttons raise interrupt and system reset
module bmc_regs
    import bmc_pkg::*;
#(
    parameter int BTO_LONG_CYC = bmc_pkg::BMC_BTO_LONG_CYC
) (
    input  wire logic        core_clk,          // System clock, 40 MHz.
    input  wire logic        nrst,              // Synchronous reset, active low.
    input  wire logic        reg_sel,           // Register access strobe.
    input  wire logic        reg_write,         // Access is a write.
    input  wire logic [7:0]  reg_addr,          // Byte offset in the window.
    input  wire logic [15:0] reg_wdata,         // Write data.
    output logic      [15:0] reg_rdata,         // Read data.
    input  wire logic        bus_select_switch, // Panel bus switch, 1 is VSB.
    input  wire logic        addr_width_switch, // 1 forces A64 display.
    input  wire logic        data_width_switch, // 1 forces D64; display needs A64 too.
    input  wire logic        sys_controller_switch, // System controller enable.
    input  wire logic        slot0_jumper,      // Fitted when in VSB slot 0.
    input  wire logic        counter_display_switch, // Show counters on lights.
    input  wire logic        long_timeout_switch, // Long bus timeout.
    input  wire logic        stop_on_ack_switch, // Stop on interrupt acknowledge.
    input  wire logic        stop_on_error_switch, // Stop on error cycle.
    input  wire logic        round_robin_switch, // Round-robin arbitration.
    input  wire logic        clear_select_left,  // Command switch pushed left.
    input  wire logic        clear_select_right, // Command switch pushed right.
    input  wire logic        irq_button,        // Interrupt push-button.
    input  wire logic        backplane_reset_button, // Reset push-button.
    input  wire logic        external_trigger_input, // Panel input, active low.
    input  wire logic        ext_input_type_jumper, // 1 gives reset, 0 interrupt.
    input  wire logic        soft_reset_enable_jumper, // Allows software reset.
    input  wire logic [7:0]  irq_vector_jumpers, // Jumpered status/vector.
    input  wire logic [2:0]  irq_level_jumpers, // Jumpered interrupt level.
    input  wire logic        irq_ack,           // Interrupt acknowledged.
    input  wire logic [7:0]  blt_count,         // Block transfer counter.
    input  wire logic [11:0] cycle_count,       // Cycle time counter.
    output logic             irq_request,       // Interrupt request, held.
    output logic             sysreset_pulse,    // System reset out, high active.
    output logic [2:0]       display_mode,      // One-hot latched/direct/monitor.
    output logic             display_clear,     // One-cycle clear of display.
    output logic             addr64_display,    // A64 display active.
    output logic             data64_display,    // 64-bit data display.
    output logic             counter_free_run,  // Counter may roll over.
    output logic             counter_bus_select, // 1 counts VSB cycles.
    output logic [3:0]       ack_delay_code,    // Monitor acknowledge delay code.
    output logic [4:0]       ack_delay_wr_cyc,  // Write acknowledge delay, cycles.
    output logic [4:0]       ack_delay_rd_cyc,  // Read acknowledge delay, cycles.
    output logic [31:0]      test_addr_lights,  // Counters for the address lights.
    output logic             test_display_on,   // Counter display active.
    output logic [13:0]      bto_limit_cyc,     // Bus timeout in cycles.
    output logic             stop_on_ack,       // Stop on acknowledge enabled.
    output logic             stop_on_error,     // Stop on error enabled.
    output logic             round_robin_arb    // Round-robin arbitration.
);
    import bmc_pkg::*;

    localparam int RST_CNT_W = $clog2(BMC_RESET_PULSE_CYC + 1);

    // Elaboration check: the long timeout must fit the 14-bit limit output.
    if (BTO_LONG_CYC < BMC_BTO_SHORT_CYC || BTO_LONG_CYC > 16383) begin : g_bad_bto
        $error("bmc_regs: timeout count out of range.");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Panel inputs are asynchronous and pass two flip-flops first.
    // The external input is inverted on the way in, so that its idle level
    // matches the zero that the flops hold in reset and no false edge follows.
    logic [15:0] pin_sync;

    bmc_sync #(.WIDTH(16)) bmc_sync_inst (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in ({bus_select_switch, addr_width_switch, data_width_switch,
                    sys_controller_switch, slot0_jumper, counter_display_switch,
                    long_timeout_switch, stop_on_ack_switch, stop_on_error_switch,
                    round_robin_switch, clear_select_left, clear_select_right,
                    irq_button, backplane_reset_button, ~external_trigger_input,
                    soft_reset_enable_jumper}),
        .sync_out (pin_sync)
    );

    logic bus_sel_s, a64_sw_s, d64_sw_s, syscon_s, slot0_s, test_sw_s;
    logic long_bto_s, iack_stop_s, err_stop_s, rrs_s, left_s, right_s;
    logic irq_btn_s, rst_btn_s, ext_s, soft_rst_en_s;

    // Unpacking of the synchronised pins; ext_s is high while the input is driven low.
    assign {bus_sel_s, a64_sw_s, d64_sw_s, syscon_s, slot0_s, test_sw_s,
            long_bto_s, iack_stop_s, err_stop_s, rrs_s, left_s, right_s,
            irq_btn_s, rst_btn_s, ext_s, soft_rst_en_s} = pin_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the synchronised buttons and strobes.
    logic left_d_reg, right_d_reg, irq_btn_d_reg, rst_btn_d_reg, ext_d_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            left_d_reg    <= 1'b0;
            right_d_reg   <= 1'b0;
            irq_btn_d_reg <= 1'b0;
            rst_btn_d_reg <= 1'b0;
            ext_d_reg     <= 1'b0;
        end else begin
            left_d_reg    <= left_s;
            right_d_reg   <= right_s;
            irq_btn_d_reg <= irq_btn_s;
            rst_btn_d_reg <= rst_btn_s;
            ext_d_reg     <= ext_s;
        end
    end

    logic left_edge, right_edge, irq_btn_edge, rst_btn_edge, ext_fall;

    // Single-cycle events from the panel.
    assign left_edge    = left_s & ~left_d_reg;
    assign right_edge   = right_s & ~right_d_reg;
    assign irq_btn_edge = irq_btn_s & ~irq_btn_d_reg;
    assign rst_btn_edge = rst_btn_s & ~rst_btn_d_reg;
    assign ext_fall     = ext_s & ~ext_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register write decode.
    logic wr_mode_cmd;

    assign wr_mode_cmd = reg_sel & reg_write & (reg_addr == BMC_MODE_CMD_OFS);

    // Writable control fields of the mode_command_status register.
    logic       a64_req_reg, d64_req_reg, irq_bit_reg, free_run_reg, cnt_sel_reg;
    logic [3:0] delay_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            a64_req_reg  <= 1'b0;
            d64_req_reg  <= 1'b0;
            irq_bit_reg  <= 1'b0;
            free_run_reg <= 1'b0;
            cnt_sel_reg  <= 1'b0;
            delay_reg    <= BMC_DELAY_RST;
        end else if (wr_mode_cmd) begin
            a64_req_reg  <= reg_wdata[BMC_A64_BIT];
            d64_req_reg  <= reg_wdata[BMC_D64_BIT];
            irq_bit_reg  <= reg_wdata[BMC_IRQ_PULSE_BIT];
            free_run_reg <= reg_wdata[BMC_FREE_RUN_BIT];
            cnt_sel_reg  <= reg_wdata[BMC_CNT_SEL_BIT];
            delay_reg    <= reg_wdata[BMC_DELAY_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display mode: software commands and the panel select switch.
    bmc_mode_t mode_reg, mode_next;
    logic [1:0] cmd;

    assign cmd = reg_wdata[BMC_MODE_LSB +: 2];

    // Next display mode; software command wins over the panel push.
    always_comb begin
        mode_next = mode_reg;
        if (wr_mode_cmd && cmd != BMC_MODE_CMD_NONE) begin
            case (cmd)
                BMC_CMD_LATCHED: mode_next = BMC_MODE_LATCHED;
                BMC_CMD_DIRECT:  mode_next = BMC_MODE_DIRECT;
                BMC_CMD_MONITOR: mode_next = BMC_MODE_MONITOR;
                default:         mode_next = mode_reg;
            endcase
        end else if (right_edge) begin
            case (mode_reg)
                BMC_MODE_LATCHED: mode_next = BMC_MODE_DIRECT;
                BMC_MODE_DIRECT:  mode_next = BMC_MODE_MONITOR;
                BMC_MODE_MONITOR: mode_next = BMC_MODE_LATCHED;
                default:          mode_next = BMC_MODE_LATCHED;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_reg <= BMC_MODE_LATCHED;
        end else begin
            mode_reg <= mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt generation and pending flag.
    logic irq_bit_d_reg, irq_fire, pending_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_bit_d_reg <= 1'b0;
        end else begin
            irq_bit_d_reg <= irq_bit_reg;
        end
    end

    // Falling edge of the software bit, a button push or the external input.
    assign irq_fire = (irq_bit_d_reg & ~irq_bit_reg)
                    | irq_btn_edge
                    | (ext_fall & ~ext_input_type_jumper);

    // A new request wins over the acknowledge in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pending_reg <= 1'b0;
        end else if (irq_fire) begin
            pending_reg <= 1'b1;
        end else if (irq_ack) begin
            pending_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibrated system reset pulse.
    logic [RST_CNT_W-1:0] rst_cnt_reg;
    logic                 rst_fire;

    assign rst_fire = (wr_mode_cmd & reg_wdata[BMC_SOFT_RST_BIT] & soft_rst_en_s)
                    | rst_btn_edge
                    | (ext_fall & ext_input_type_jumper);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rst_cnt_reg <= '0;
        end else if (rst_fire) begin
            rst_cnt_reg <= RST_CNT_W'(BMC_RESET_PULSE_CYC);
        end else if (rst_cnt_reg != '0) begin
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data path.
    logic [15:0] mcs_read, ils_read, rdata_next;

    // Low nibble status, middle nibble read/write, high byte reads zero.
    assign mcs_read = {8'h00,
                       slot0_s,
                       syscon_s,
                       d64_req_reg | d64_sw_s,
                       a64_req_reg | a64_sw_s,
                       mode_reg == BMC_MODE_DIRECT,
                       mode_reg == BMC_MODE_MONITOR,
                       mode_reg == BMC_MODE_LATCHED,
                       bus_sel_s};

    // Upper nibble is undefined; it reads zero.
    assign ils_read = {4'h0, pending_reg, irq_level_jumpers,
                       irq_vector_jumpers};

    always_comb begin
        rdata_next = 16'h0000;
        if (reg_sel && !reg_write) begin
            case (reg_addr)
                BMC_MODE_CMD_OFS: rdata_next = mcs_read;
                BMC_IRQ_ID_OFS:   rdata_next = ils_read;
                BMC_CYC_CNT_OFS:  rdata_next = {1'b0, err_stop_s, rrs_s,
                                                cnt_sel_reg, cycle_count};
                default:          rdata_next = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers.
    logic a64_eff, d64_eff;

    assign a64_eff = a64_sw_s | a64_req_reg;
    assign d64_eff = d64_sw_s | d64_req_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata          <= 16'h0000;
            irq_request        <= 1'b0;
            sysreset_pulse     <= 1'b0;
            display_mode       <= BMC_MODE_LATCHED;
            display_clear      <= 1'b0;
            addr64_display     <= 1'b0;
            data64_display     <= 1'b0;
            counter_free_run   <= 1'b0;
            counter_bus_select <= 1'b0;
            ack_delay_code     <= BMC_DELAY_RST;
            ack_delay_wr_cyc   <= 5'h00;
            ack_delay_rd_cyc   <= 5'h00;
            test_addr_lights   <= 32'h0000_0000;
            test_display_on    <= 1'b0;
            bto_limit_cyc      <= 14'h0000;
            stop_on_ack        <= 1'b0;
            stop_on_error      <= 1'b0;
            round_robin_arb    <= 1'b0;
        end else begin
            reg_rdata          <= rdata_next;
            irq_request        <= pending_reg;
            sysreset_pulse     <= rst_cnt_reg != '0;
            display_mode       <= mode_reg;
            display_clear      <= left_edge;
            addr64_display     <= a64_eff;
            data64_display     <= a64_eff & d64_eff;
            counter_free_run   <= free_run_reg;
            counter_bus_select <= cnt_sel_reg;
            ack_delay_code     <= delay_reg;
            ack_delay_wr_cyc   <= 5'((BMC_ACK_WR_BASE_PS
                                 + (15 - int'(delay_reg)) * BMC_ACK_STEP_PS
                                 + BMC_CLK_PS - 1) / BMC_CLK_PS);
            ack_delay_rd_cyc   <= 5'((BMC_ACK_RD_BASE_PS
                                 + (15 - int'(delay_reg)) * BMC_ACK_STEP_PS
                                 + BMC_CLK_PS - 1) / BMC_CLK_PS);
            test_addr_lights   <= {8'h00, blt_count, 4'h0, cycle_count};
            test_display_on    <= test_sw_s;
            bto_limit_cyc      <= long_bto_s ? 14'(BTO_LONG_CYC)
                                         : 14'(BMC_BTO_SHORT_CYC);
            stop_on_ack        <= iack_stop_s;
            stop_on_error      <= err_stop_s;
            round_robin_arb    <= rrs_s;
        end
    end

endmodule : bmc_regs
`default_nettype wire

// >>> dv/bmc_regs_props.sv
// Assertion checker for the control and status register block.
`timescale 1ns/1ps
`default_nettype none
module bmc_regs_props #(parameter int BTO_LONG_CYC = 700) (
    input wire logic        core_clk, // Clock.
    input wire logic        nrst, // Reset.
    input wire logic        reg_sel, // Strobe.
    input wire logic        reg_write, // Write.
    input wire logic [7:0]  reg_addr, // Offset.
    input wire logic [15:0] reg_wdata, // Write data.
    input wire logic [15:0] reg_rdata, // Read data.
    input wire logic        irq_request, // Interrupt.
    input wire logic        sysreset_pulse, // Reset out.
    input wire logic [2:0]  display_mode, // Mode.
    input wire logic        counter_bus_select, // Counter bus.
    input wire logic [3:0]  ack_delay_code, // Delay code.
    input wire logic [4:0]  ack_delay_wr_cyc, // Write delay.
    input wire logic [13:0] bto_limit_cyc // Timeout.
);
    // Decoded writes and the expected write acknowledge delay, rounded up.
    wire logic wr1c = reg_sel && reg_write && reg_addr == 8'h1C;
    wire logic [4:0] wr_exp = 5'((96750 + 31250 * (15 - ack_delay_code) + 24999) / 25000);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_idle; !(reg_sel && !reg_write) |=> reg_rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_mode;
        wr1c && reg_wdata[9:8] != 2'h0 |->
            ##2 display_mode == 3'h1 << ($past(reg_wdata[9:8], 2) - 2'h1);
    endproperty
    a_mode: assert property (p_mode) else $error("wrong display mode");
    property p_sel; wr1c |-> ##2 counter_bus_select == $past(reg_wdata[10], 2); endproperty
    a_sel: assert property (p_sel) else $error("counter source not taken");
    property p_dly; $stable(ack_delay_code) && $past(nrst) && $past(nrst, 2)
        |-> ack_delay_wr_cyc == wr_exp; endproperty
    a_dly: assert property (p_dly) else $error("write delay wrong");
    property p_pls; $rose(sysreset_pulse) |-> sysreset_pulse [*8] ##1 !sysreset_pulse; endproperty
    a_pls: assert property (p_pls) else $error("reset pulse width wrong");
    property p_irq; wr1c && !reg_wdata[6] && $past(wr1c, 2) && $past(reg_wdata[6], 2)
        |-> ##[1:4] irq_request; endproperty
    a_irq: assert property (p_irq) else $error("no interrupt after pulse");
    property p_rise; wr1c && reg_wdata[6] && !irq_request |-> ##1 !irq_request [*3]; endproperty
    a_rise: assert property (p_rise) else $error("interrupt on rising bit");
    property p_bto; $past(nrst) |->
        bto_limit_cyc == 14'd600 || bto_limit_cyc == 14'(BTO_LONG_CYC); endproperty
    a_bto: assert property (p_bto) else $error("bus timeout value wrong");
endmodule : bmc_regs_props
`default_nettype wire

// >>> dv/bmc_host.sv
// Bus master model that reaches the registers one word at a time.
`timescale 1ns/1ps
`default_nettype none
module bmc_host (
    input  wire logic        core_clk, // Clock.
    output logic             reg_sel, // Strobe.
    output logic             reg_write, // Write.
    output logic [7:0]       reg_addr, // Offset.
    output logic [15:0]      reg_wdata, // Write data.
    input  wire logic [15:0] reg_rdata // Read data.
);
    // The bus is idle from time zero.
    initial {reg_sel, reg_write, reg_addr, reg_wdata} = '0;
    // Request held through its taking edge; the answer is taken just after it.
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge core_clk);
        #1;
        {reg_sel, reg_write, reg_addr, reg_wdata} = {1'b1, w, a, d};
        @(posedge core_clk);
        #1;
        q = reg_rdata;
        // Released lines show the inverse so that stale values are never trusted.
        {reg_sel, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask : acc
    // One word write.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        acc(1'b1, a, d, q);
    endtask : wr
endmodule : bmc_host
`default_nettype wire

// >>> dv/bmc_regs_tb.sv
// Self-checking testbench for the control and status register block.
`timescale 1ns/1ps
`default_nettype none
module bmc_regs_tb;
    import bmc_pkg::*;
    // Inputs of the block: clock, reset, panel, jumpers and counters.
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic bus_select_switch, addr_width_switch, data_width_switch, sys_controller_switch;
    logic slot0_jumper, counter_display_switch, long_timeout_switch, stop_on_ack_switch;
    logic stop_on_error_switch, round_robin_switch, clear_select_left, clear_select_right;
    logic irq_button, backplane_reset_button, external_trigger_input, ext_input_type_jumper;
    logic soft_reset_enable_jumper, irq_ack;
    logic [7:0] irq_vector_jumpers = 8'hA5;
    logic [2:0] irq_level_jumpers = 3'h5;
    logic [7:0] blt_count = 8'h3C;
    logic [11:0] cycle_count = 12'hABC;
    // Outputs of the block and the bus lines of the master model.
    logic reg_sel, reg_write, irq_request, sysreset_pulse, display_clear, addr64_display;
    logic data64_display, counter_free_run, counter_bus_select, test_display_on;
    logic stop_on_ack, stop_on_error, round_robin_arb;
    logic [2:0] display_mode;
    logic [3:0] ack_delay_code;
    logic [4:0] ack_delay_wr_cyc, ack_delay_rd_cyc;
    logic [7:0] reg_addr;
    logic [13:0] bto_limit_cyc;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic [31:0] test_addr_lights;
    int fail_count = 0;
    int tests_run = 0;
    bmc_regs #(.BTO_LONG_CYC(700)) bmc_regs_inst (.*);
    bmc_host bmc_host_inst (.*);
    // Clock of 25 ns period.
    initial forever #12.5 core_clk = ~core_clk;
    // Compares one word and counts the outcome.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
        if (got !== exp) fail_count++;
    endtask : chk
    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict();
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // Values after reset, the jumpered register and an unmapped offset.
    task automatic t_reset();
        bmc_host_inst.acc(1'b0, BMC_MODE_CMD_OFS, 16'h0000, rd);
        chk(rd, 16'h0002);
        chk(16'({ack_delay_wr_cyc, ack_delay_rd_cyc}), 16'h0086);
        bmc_host_inst.acc(1'b0, BMC_IRQ_ID_OFS, 16'h0000, rd);
        chk(rd, 16'h05A5);
        bmc_host_inst.acc(1'b0, 8'h40, 16'h0000, rd);
        chk(rd, 16'h0000);
    endtask : t_reset
    // Every mode command with A64, D64, free run and counter source set.
    task automatic t_mode();
        for (int c = 1; c < 4; c++) begin
            bmc_host_inst.wr(BMC_MODE_CMD_OFS, 16'hF4B0 | 16'(c << 8));
            bmc_host_inst.acc(1'b0, BMC_MODE_CMD_OFS, 16'h0000, rd);
            chk(rd, 16'h0030 | 16'(c == 1 ? 2 : (c == 2 ? 8 : 4)));
        end
        chk(16'({data64_display, counter_free_run}), 16'h0003);
        bmc_host_inst.acc(1'b0, BMC_CYC_CNT_OFS, 16'h0000, rd);
        chk(rd, 16'h1ABC);
    endtask : t_mode
    // Software pulse on the interrupt bit, then the pending flag.
    task automatic t_irq();
        bmc_host_inst.wr(BMC_MODE_CMD_OFS, 16'hF040);
        bmc_host_inst.wr(BMC_MODE_CMD_OFS, 16'hF000);
        for (int i = 0; i < 9 && irq_request !== 1'b1; i++) #25;
        chk(16'(irq_request), 16'h0001);
        if (irq_request !== 1'b1) give_verdict();
        bmc_host_inst.acc(1'b0, BMC_IRQ_ID_OFS, 16'h0000, rd);
        chk(rd, 16'h0DA5);
    endtask : t_irq
    // Software system reset with the jumper fitted gives one pulse.
    task automatic t_srst();
        int n = 0;
        bmc_host_inst.wr(BMC_MODE_CMD_OFS, 16'hF800);
        for (int i = 0; i < 9 && sysreset_pulse !== 1'b1; i++) #25;
        while (sysreset_pulse === 1'b1 && n < 20) begin
            #25;
            n++;
        end
        chk(16'(n), 16'(BMC_RESET_PULSE_CYC));
    endtask : t_srst
    // Static panel switches reach their outputs; the command switch steps and clears.
    task automatic t_panel();
        {counter_display_switch, long_timeout_switch, stop_on_ack_switch} = 3'h7;
        {stop_on_error_switch, round_robin_switch, clear_select_right} = 3'h7;
        repeat (5) @(posedge core_clk);
        #1;
        chk(test_addr_lights[31:16], 16'h003C);
        chk(test_addr_lights[15:0], 16'h0ABC);
        chk(16'({test_display_on, stop_on_ack, stop_on_error, round_robin_arb}), 16'h000F);
        chk(16'(bto_limit_cyc), 16'h02BC);
        chk(16'(display_mode), 16'h0001);
        clear_select_left = 1'b1;
        for (int i = 0; i < 9 && display_clear !== 1'b1; i++) #25;
        chk(16'(display_clear), 16'h0001);
        #25;
        chk(16'(display_clear), 16'h0000);
    endtask : t_panel
    // Reset for sixteen cycles, then the scenarios in turn.
    initial begin
        {bus_select_switch, addr_width_switch, data_width_switch, sys_controller_switch,
         slot0_jumper, counter_display_switch, long_timeout_switch, stop_on_ack_switch,
         stop_on_error_switch, round_robin_switch, clear_select_left, clear_select_right,
         irq_button, backplane_reset_button, ext_input_type_jumper, irq_ack} = '0;
        {external_trigger_input, soft_reset_enable_jumper} = 2'h3;
        repeat (16) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_mode();
        t_irq();
        t_srst();
        t_panel();
        give_verdict();
    end
endmodule : bmc_regs_tb
bind bmc_regs bmc_regs_props #(.BTO_LONG_CYC(BTO_LONG_CYC)) bmc_regs_props_inst (.*);
`default_nettype wire
